// File: rtl/sld_pkg.sv
// constants and types shared by the short load and move decoder
package sld_pkg;
	// major opcodes, instruction bits 15..10
	localparam logic [5:0] POOL16C_MAJOR = 6'h11;
	localparam logic [5:0] GP_LOAD_MAJOR = 6'h19;
	localparam logic [5:0] COPY_MAJOR    = 6'h03;
	// minor code of the short load-multiple, bits 3..0 under the pool major
	localparam logic [3:0] LMULT_MINOR   = 4'h2;

	// field positions
	localparam int MAJOR_LSB     = 10;
	localparam int DEST3_LSB     = 7;
	localparam int SRC1_LSB      = 4;
	localparam int SRC2_LSB      = 1;
	localparam int COPY_DST_LSB  = 5;
	localparam int LM_LIST_LSB   = 8;
	localparam int LM_OFF_LSB    = 4;

	// fixed register numbers
	localparam logic [4:0] GP_REG    = 5'h1c;
	localparam logic [4:0] SP_REG    = 5'h1d;
	localparam logic [4:0] RA_REG    = 5'h1f;
	localparam logic [4:0] LM_FIRST  = 5'h10;

	// address step between loaded words, in bytes
	localparam int WORD_STEP = 4;

	// reset value of the register-number outputs
	localparam logic [4:0] REG_RESET = 5'h00;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_LMULT,
		OP_GP_LOAD,
		OP_SP_LOAD,
		OP_COPY,
		OP_PAIR
	} sld_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_LOAD
	} sld_state_e;
endpackage

// File: rtl/sld_reg_map.sv
// register-number decoding for the compact 3-bit register fields
`timescale 1ns/1ps
`default_nettype none
module sld_reg_map (
	input  wire logic [2:0] dest_code_in,
	input  wire logic [2:0] src1_code_in,
	input  wire logic [2:0] src2_code_in,
	output logic      [4:0] dest1_out,
	output logic      [4:0] dest2_out,
	output logic      [4:0] src1_out,
	output logic      [4:0] src2_out,
	output logic      [4:0] compact_out
);
	function automatic logic [4:0] src_decode(input logic [2:0] code);
		case (code)
			3'h0: src_decode = 5'h00;
			3'h1: src_decode = 5'h11;
			3'h2: src_decode = 5'h02;
			3'h3: src_decode = 5'h03;
			3'h4: src_decode = 5'h10;
			3'h5: src_decode = 5'h12;
			3'h6: src_decode = 5'h13;
			default: src_decode = 5'h14;
		endcase
	endfunction

	// both source fields share one table
	assign src1_out = src_decode(src1_code_in);
	assign src2_out = src_decode(src2_code_in);

	always_comb begin
		case (dest_code_in)
			3'h0: begin dest1_out = 5'h05; dest2_out = 5'h06; end
			3'h1: begin dest1_out = 5'h05; dest2_out = 5'h07; end
			3'h2: begin dest1_out = 5'h06; dest2_out = 5'h07; end
			3'h3: begin dest1_out = 5'h04; dest2_out = 5'h15; end
			3'h4: begin dest1_out = 5'h04; dest2_out = 5'h16; end
			3'h5: begin dest1_out = 5'h04; dest2_out = 5'h05; end
			3'h6: begin dest1_out = 5'h04; dest2_out = 5'h06; end
			default: begin dest1_out = 5'h04; dest2_out = 5'h07; end
		endcase
	end

	// 0..5 map to 2..7, 6 and 7 map to 16 and 17
	always_comb begin
		if (dest_code_in[2:1] == 2'h3) begin
			compact_out = {4'h8, dest_code_in[0]};
		end else begin
			compact_out = {2'h0, dest_code_in} + 5'h02;
		end
	end
endmodule
`default_nettype wire

// File: rtl/sld_short_load_move_decode.sv
// decoder and sequencer for the short loads and register copies
`timescale 1ns/1ps
`default_nettype none
module sld_short_load_move_decode #(
	parameter int         XLEN          = 64,
	parameter logic [5:0] SP_LOAD_MAJOR = 6'h12,
	parameter logic [5:0] PAIR_MAJOR    = 6'h21
) (
	input  wire logic            sys_clk_in,
	input  wire logic            srst_in,
	input  wire logic            instr_valid_in,
	input  wire logic [15:0]     instr_in,
	input  wire logic            big_endian_in,
	input  wire logic            reverse_endian_in,
	output logic                 instr_ready_out,
	output logic      [4:0]      rd_addr_a_out,
	input  wire logic [XLEN-1:0] rd_data_a_in,
	output logic      [4:0]      rd_addr_b_out,
	input  wire logic [XLEN-1:0] rd_data_b_in,
	output logic                 wr_en_a_out,
	output logic      [4:0]      wr_addr_a_out,
	output logic      [XLEN-1:0] wr_data_a_out,
	output logic                 wr_en_b_out,
	output logic      [4:0]      wr_addr_b_out,
	output logic      [XLEN-1:0] wr_data_b_out,
	output logic                 ld_req_out,
	output logic      [XLEN-1:0] ld_vaddr_out,
	output logic      [XLEN-1:0] ld_paddr_out,
	input  wire logic            ld_ack_in,
	input  wire logic [63:0]     ld_data_in,
	output logic                 addr_err_out,
	output logic      [XLEN-1:0] bad_vaddr_out,
	output logic                 unknown_out,
	output logic                 done_out,
	output logic                 irq_hold_out
);
	sld_pkg::sld_state_e state_reg;
	sld_pkg::sld_op_e    op_reg;
	logic [15:0]         instr_reg;
	logic [XLEN-1:0]     vaddr_reg;
	logic [4:0]          tgt_reg;
	logic [2:0]          idx_reg;
	logic [2:0]          last_reg;
	logic [XLEN-1:0]     ea_next;
	logic                misaligned;
	logic                is_load;
	logic [4:0]          dest1;
	logic [4:0]          dest2;
	logic [4:0]          src1;
	logic [4:0]          src2;
	logic [4:0]          compact_tgt;
	logic [XLEN-1:0]     picked_word;
	logic                more_words;

	function automatic sld_pkg::sld_op_e classify(input logic [15:0] ins);
		logic [5:0] major;
		major = ins[15:sld_pkg::MAJOR_LSB];
		if (major == sld_pkg::POOL16C_MAJOR &&
		    ins[3:0] == sld_pkg::LMULT_MINOR) begin
			classify = sld_pkg::OP_LMULT;
		end else if (major == sld_pkg::GP_LOAD_MAJOR) begin
			classify = sld_pkg::OP_GP_LOAD;
		end else if (major == SP_LOAD_MAJOR) begin
			classify = sld_pkg::OP_SP_LOAD;
		end else if (major == sld_pkg::COPY_MAJOR) begin
			classify = sld_pkg::OP_COPY;
		end else if (major == PAIR_MAJOR) begin
			classify = sld_pkg::OP_PAIR;
		end else begin
			classify = sld_pkg::OP_NONE;
		end
	endfunction

	// list entries are 16, 17.. in order, the last one is always 31
	function automatic logic [4:0] lm_reg(input logic [2:0] idx,
	                                      input logic [2:0] last);
		if (idx == last) begin
			lm_reg = sld_pkg::RA_REG;
		end else begin
			lm_reg = sld_pkg::LM_FIRST + {2'h0, idx};
		end
	endfunction

	sld_reg_map u_reg_map (
		.dest_code_in (instr_reg[sld_pkg::DEST3_LSB +: 3]),
		.src1_code_in (instr_reg[sld_pkg::SRC1_LSB +: 3]),
		.src2_code_in (instr_reg[sld_pkg::SRC2_LSB +: 3]),
		.dest1_out    (dest1),
		.dest2_out    (dest2),
		.src1_out     (src1),
		.src2_out     (src2),
		.compact_out  (compact_tgt)
	);

	sld_word_pick #(
		.XLEN (XLEN)
	) u_word_pick (
		.dword_in      (ld_data_in),
		.vaddr_lo_in   (vaddr_reg[2:0]),
		.big_endian_in (big_endian_in),
		.word_out      (picked_word)
	);

	// register read selection during the execute cycle
	always_comb begin
		rd_addr_a_out = sld_pkg::REG_RESET;
		rd_addr_b_out = sld_pkg::REG_RESET;
		case (op_reg)
			sld_pkg::OP_LMULT: rd_addr_a_out = sld_pkg::SP_REG;
			sld_pkg::OP_SP_LOAD: rd_addr_a_out = sld_pkg::SP_REG;
			sld_pkg::OP_GP_LOAD: rd_addr_a_out = sld_pkg::GP_REG;
			sld_pkg::OP_COPY: rd_addr_a_out = instr_reg[4:0];
			sld_pkg::OP_PAIR: begin
				rd_addr_a_out = src1;
				rd_addr_b_out = src2;
			end
			default: rd_addr_a_out = sld_pkg::REG_RESET;
		endcase
	end

	// effective address of the first word
	always_comb begin
		case (op_reg)
			sld_pkg::OP_LMULT: ea_next = rd_data_a_in + {{(XLEN-6){1'b0}},
				instr_reg[sld_pkg::LM_OFF_LSB +: 4], 2'h0};
			sld_pkg::OP_GP_LOAD: ea_next = rd_data_a_in +
				{{(XLEN-9){instr_reg[6]}}, instr_reg[6:0], 2'h0};
			sld_pkg::OP_SP_LOAD: ea_next = rd_data_a_in +
				{{(XLEN-7){1'b0}}, instr_reg[4:0], 2'h0};
			default: ea_next = rd_data_a_in;
		endcase
	end

	assign is_load = op_reg == sld_pkg::OP_LMULT ||
	                 op_reg == sld_pkg::OP_GP_LOAD ||
	                 op_reg == sld_pkg::OP_SP_LOAD;
	assign misaligned = ea_next[1:0] != 2'h0;
	assign more_words = op_reg == sld_pkg::OP_LMULT && idx_reg != last_reg;

	assign instr_ready_out = state_reg == sld_pkg::ST_IDLE;
	assign ld_req_out      = state_reg == sld_pkg::ST_LOAD;
	assign ld_vaddr_out    = vaddr_reg;
	assign ld_paddr_out    = {vaddr_reg[XLEN-1:3],
	                          vaddr_reg[2:0] ^ {reverse_endian_in, 2'h0}};
	// chosen: hold interrupts off in the execute cycle of pair copies and the load cycles of load-multiples
	assign irq_hold_out = (state_reg == sld_pkg::ST_EXEC &&
	                       op_reg == sld_pkg::OP_PAIR) ||
	                      (state_reg == sld_pkg::ST_LOAD &&
	                       op_reg == sld_pkg::OP_LMULT);

	// sequencing
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg <= sld_pkg::ST_IDLE;
			op_reg    <= sld_pkg::OP_NONE;
			instr_reg <= 16'h0000;
			vaddr_reg <= '0;
			tgt_reg   <= sld_pkg::REG_RESET;
			idx_reg   <= 3'h0;
			last_reg  <= 3'h0;
		end else begin
			case (state_reg)
				sld_pkg::ST_IDLE: begin
					if (instr_valid_in) begin
						instr_reg <= instr_in;
						op_reg    <= classify(instr_in);
						state_reg <= sld_pkg::ST_EXEC;
					end
				end
				sld_pkg::ST_EXEC: begin
					// the alignment check comes first so a misaligned load never issues a read
					if (is_load && !misaligned) begin
						vaddr_reg <= ea_next;
						idx_reg   <= 3'h0;
						last_reg  <= {1'b0, instr_reg[sld_pkg::LM_LIST_LSB +: 2]}
						             + 3'h1;
						if (op_reg == sld_pkg::OP_LMULT) begin
							tgt_reg <= sld_pkg::LM_FIRST;
						end else if (op_reg == sld_pkg::OP_GP_LOAD) begin
							tgt_reg <= compact_tgt;
						end else begin
							tgt_reg <= instr_reg[9:5];
						end
						state_reg <= sld_pkg::ST_LOAD;
					end else begin
						state_reg <= sld_pkg::ST_IDLE;
					end
				end
				sld_pkg::ST_LOAD: begin
					if (ld_ack_in) begin
						if (more_words) begin
							idx_reg   <= idx_reg + 3'h1;
							tgt_reg   <= lm_reg(idx_reg + 3'h1, last_reg);
							vaddr_reg <= vaddr_reg +
							             XLEN'(sld_pkg::WORD_STEP);
						end else begin
							state_reg <= sld_pkg::ST_IDLE;
						end
					end
				end
				default: state_reg <= sld_pkg::ST_IDLE;
			endcase
		end
	end

	// register file writes
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			wr_en_a_out   <= 1'b0;
			wr_addr_a_out <= sld_pkg::REG_RESET;
			wr_data_a_out <= '0;
			wr_en_b_out   <= 1'b0;
			wr_addr_b_out <= sld_pkg::REG_RESET;
			wr_data_b_out <= '0;
		end else begin
			wr_en_a_out <= 1'b0;
			wr_en_b_out <= 1'b0;
			if (state_reg == sld_pkg::ST_EXEC &&
			    op_reg == sld_pkg::OP_COPY) begin
				wr_en_a_out   <= 1'b1;
				wr_addr_a_out <= instr_reg[sld_pkg::COPY_DST_LSB +: 5];
				wr_data_a_out <= rd_data_a_in;
			end else if (state_reg == sld_pkg::ST_EXEC &&
			             op_reg == sld_pkg::OP_PAIR) begin
				// both sources were read before either write lands
				wr_en_a_out   <= 1'b1;
				wr_addr_a_out <= dest1;
				wr_data_a_out <= rd_data_a_in;
				wr_en_b_out   <= 1'b1;
				wr_addr_b_out <= dest2;
				wr_data_b_out <= rd_data_b_in;
			end else if (state_reg == sld_pkg::ST_LOAD && ld_ack_in) begin
				wr_en_a_out   <= 1'b1;
				wr_addr_a_out <= tgt_reg;
				wr_data_a_out <= picked_word;
			end
		end
	end

	// completion and fault reporting
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			addr_err_out  <= 1'b0;
			bad_vaddr_out <= '0;
			unknown_out   <= 1'b0;
			done_out      <= 1'b0;
		end else begin
			addr_err_out <= 1'b0;
			unknown_out  <= 1'b0;
			done_out     <= 1'b0;
			if (state_reg == sld_pkg::ST_EXEC) begin
				if (is_load && misaligned) begin
					addr_err_out  <= 1'b1;
					bad_vaddr_out <= ea_next;
				end else if (op_reg == sld_pkg::OP_NONE) begin
					unknown_out <= 1'b1;
				end else if (!is_load) begin
					done_out <= 1'b1;
				end
			end else if (state_reg == sld_pkg::ST_LOAD && ld_ack_in &&
			             !more_words) begin
				done_out <= 1'b1;
			end
		end
	end

	misalign_no_read_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		addr_err_out |-> !ld_req_out && !wr_en_a_out ##1 !ld_req_out)
		else $error("read or write after address error");

	addr_err_low_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		addr_err_out |-> bad_vaddr_out[1:0] != 2'h0 &&
		$past(is_load && state_reg == sld_pkg::ST_EXEC))
		else $error("address error without misaligned load");

	lm_step_four_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(ld_ack_in && ld_req_out && more_words) |=>
		ld_vaddr_out == $past(ld_vaddr_out) + XLEN'(sld_pkg::WORD_STEP))
		else $error("load-multiple address did not step by four");

	gp_addr_form_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(state_reg == sld_pkg::ST_EXEC && op_reg == sld_pkg::OP_GP_LOAD &&
		 !misaligned) |-> rd_addr_a_out == 5'h1c ##1
		ld_req_out && ld_vaddr_out[1:0] == 2'h0)
		else $error("global-pointer load address wrong");

	gp_target_set_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(ld_req_out && op_reg == sld_pkg::OP_GP_LOAD) |->
		(tgt_reg inside {[5'h02:5'h07], 5'h10, 5'h11}))
		else $error("compact target outside allowed set");

	load_sign_ext_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(ld_req_out && ld_ack_in) |=> wr_en_a_out &&
		wr_data_a_out[XLEN-1:31] == {(XLEN-31){wr_data_a_out[31]}})
		else $error("loaded word not sign-extended");

	copy_write_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(state_reg == sld_pkg::ST_EXEC && op_reg == sld_pkg::OP_COPY) |=>
		wr_en_a_out && !addr_err_out &&
		wr_data_a_out == $past(rd_data_a_in) &&
		wr_addr_a_out == $past(instr_reg[9:5]))
		else $error("single copy wrong");

	pair_both_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(state_reg == sld_pkg::ST_EXEC && op_reg == sld_pkg::OP_PAIR) |=>
		wr_en_a_out && wr_en_b_out && wr_data_b_out == $past(rd_data_b_in))
		else $error("pair copy did not write both registers");

	pair_dest_three_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(state_reg == sld_pkg::ST_EXEC && op_reg == sld_pkg::OP_PAIR &&
		 instr_reg[9:7] == 3'h3) |=>
		wr_addr_a_out == 5'h04 && wr_addr_b_out == 5'h15)
		else $error("pair destination code 3 wrong");

	pair_src_one_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(op_reg == sld_pkg::OP_PAIR && instr_reg[6:4] == 3'h1) |->
		rd_addr_a_out == 5'h11)
		else $error("source code 1 not register 17");

	lm_order_a: assert property (@(posedge sys_clk_in)
		disable iff (srst_in)
		(ld_req_out && op_reg == sld_pkg::OP_LMULT) |->
		(idx_reg == last_reg ? tgt_reg == 5'h1f :
		 tgt_reg == 5'h10 + {2'h0, idx_reg}))
		else $error("load-multiple register order wrong");
endmodule
`default_nettype wire

// File: rtl/sld_word_pick.sv
// picks the addressed word out of a loaded doubleword and sign-extends it
`timescale 1ns/1ps
`default_nettype none
module sld_word_pick #(
	parameter int XLEN = 64
) (
	input  wire logic [63:0]     dword_in,
	input  wire logic [2:0]      vaddr_lo_in,
	input  wire logic            big_endian_in,
	output logic      [XLEN-1:0] word_out
);
	logic [2:0]  lane;
	logic [31:0] word;

	// only lanes 0 and 4 occur, misaligned loads never get here
	assign lane = vaddr_lo_in ^ {big_endian_in, 2'h0};
	assign word = lane[2] ? dword_in[63:32] : dword_in[31:0];
	assign word_out = {{(XLEN-32){word[31]}}, word};
endmodule
`default_nettype wire

// File: tb/sld_core_model.sv
// register file and load path standing beside the decoder
`timescale 1ns/1ps
`default_nettype none
module sld_core_model #(
	parameter int XLEN = 64
) (
	input  wire logic            sys_clk_in,
	input  wire logic            srst_in,
	input  wire logic [4:0]      rd_addr_a_in,
	input  wire logic [4:0]      rd_addr_b_in,
	output logic      [XLEN-1:0] rd_data_a_out,
	output logic      [XLEN-1:0] rd_data_b_out,
	input  wire logic            wr_en_a_in,
	input  wire logic [4:0]      wr_addr_a_in,
	input  wire logic [XLEN-1:0] wr_data_a_in,
	input  wire logic            wr_en_b_in,
	input  wire logic [4:0]      wr_addr_b_in,
	input  wire logic [XLEN-1:0] wr_data_b_in,
	input  wire logic            ld_req_in,
	input  wire logic [XLEN-1:0] ld_paddr_in,
	output logic                 ld_ack_out,
	output logic      [63:0]     ld_data_out
);
	logic [XLEN-1:0] gpr [32];
	logic [63:0]     mem [256];
	int              ack_delay;
	int              wait_cnt;

	// register zero always reads as zero, whatever was written there
	assign rd_data_a_out = (rd_addr_a_in == 5'h00) ? '0 : gpr[rd_addr_a_in];
	assign rd_data_b_out = (rd_addr_b_in == 5'h00) ? '0 : gpr[rd_addr_b_in];

	initial begin
		ack_delay = 0;
		wait_cnt = 0;
		ld_ack_out = 1'b0;
		ld_data_out = 64'h0;
	end

	// data is only good with the ack; otherwise it toggles every cycle
	always @(posedge sys_clk_in) begin
		ld_ack_out <= 1'b0;
		ld_data_out <= ~ld_data_out;
		if (srst_in) begin
			wait_cnt <= 0;
		end else if (ld_req_in && !ld_ack_out) begin
			if (wait_cnt >= ack_delay) begin
				ld_ack_out <= 1'b1;
				ld_data_out <= mem[ld_paddr_in[10:3]];
				wait_cnt <= 0;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
		if (wr_en_a_in && wr_addr_a_in != 5'h00)
			gpr[wr_addr_a_in] <= wr_data_a_in;
		if (wr_en_b_in && wr_addr_b_in != 5'h00)
			gpr[wr_addr_b_in] <= wr_data_b_in;
	end
endmodule
`default_nettype wire

// File: tb/sld_short_load_move_decode_test.sv
// self-checking bench for the short load and move decoder
`timescale 1ns/1ps
`default_nettype none
module sld_short_load_move_decode_test;
	localparam logic [5:0] SP_MAJ   = 6'h12;
	localparam logic [5:0] PAIR_MAJ = 6'h21;
	logic        sys_clk_in, srst_in, instr_valid_in, instr_ready_out;
	logic        big_endian_in, reverse_endian_in, ld_req_out, ld_ack_in;
	logic        wr_en_a_out, wr_en_b_out, addr_err_out, unknown_out;
	logic        done_out, irq_hold_out;
	logic [15:0] instr_in;
	logic [4:0]  rd_addr_a_out, rd_addr_b_out, wr_addr_a_out, wr_addr_b_out;
	logic [63:0] rd_data_a_in, rd_data_b_in, wr_data_a_out, wr_data_b_out;
	logic [63:0] ld_vaddr_out, ld_paddr_out, ld_data_in, bad_vaddr_out;
	logic [63:0] exp_gpr [32];
	logic [68:0] exp_a [$];
	logic [68:0] exp_b [$];
	logic [63:0] exp_va [$];
	logic [63:0] va_e;
	logic [63:0] exp_bad;
	logic        be_v, rev_v;
	int          num_errors = 0;
	int          compares = 0;
	int          req_seen, hold_seen;
	int          dst1_t [8] = '{5, 5, 6, 4, 4, 4, 4, 4};
	int          dst2_t [8] = '{6, 7, 7, 21, 22, 5, 6, 7};
	int          src_t [8] = '{0, 17, 2, 3, 16, 18, 19, 20};

	sld_short_load_move_decode #(
		.XLEN          (64),
		.SP_LOAD_MAJOR (SP_MAJ),
		.PAIR_MAJOR    (PAIR_MAJ)
	) i_sld_short_load_move_decode (
		.sys_clk_in, .srst_in, .instr_valid_in, .instr_in, .big_endian_in,
		.reverse_endian_in, .instr_ready_out, .rd_addr_a_out, .rd_data_a_in,
		.rd_addr_b_out, .rd_data_b_in, .wr_en_a_out, .wr_addr_a_out,
		.wr_data_a_out, .wr_en_b_out, .wr_addr_b_out, .wr_data_b_out,
		.ld_req_out, .ld_vaddr_out, .ld_paddr_out, .ld_ack_in, .ld_data_in,
		.addr_err_out, .bad_vaddr_out, .unknown_out, .done_out, .irq_hold_out
	);

	sld_core_model #(.XLEN(64)) i_sld_core_model (
		.sys_clk_in    (sys_clk_in),
		.srst_in       (srst_in),
		.rd_addr_a_in  (rd_addr_a_out),
		.rd_addr_b_in  (rd_addr_b_out),
		.rd_data_a_out (rd_data_a_in),
		.rd_data_b_out (rd_data_b_in),
		.wr_en_a_in    (wr_en_a_out),
		.wr_addr_a_in  (wr_addr_a_out),
		.wr_data_a_in  (wr_data_a_out),
		.wr_en_b_in    (wr_en_b_out),
		.wr_addr_b_in  (wr_addr_b_out),
		.wr_data_b_in  (wr_data_b_out),
		.ld_req_in     (ld_req_out),
		.ld_paddr_in   (ld_paddr_out),
		.ld_ack_out    (ld_ack_in),
		.ld_data_out   (ld_data_in)
	);

	always #10 sys_clk_in = ~sys_clk_in;

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic fail(input string msg);
		num_errors++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask

	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
			fail($sformatf("value %h, expected %h", got, exp));
	endtask

	task automatic check_num(input int got, input int exp);
		compares++;
		if (got != exp)
			fail($sformatf("count %0d, expected %0d", got, exp));
	endtask

	// pops the next expected write of that port and compares it
	task automatic check_wr(input logic [68:0] got, input bit port_b);
		logic [68:0] e;
		compares++;
		if ((port_b ? exp_b.size() : exp_a.size()) == 0) begin
			fail("register write not expected");
			return;
		end
		e = port_b ? exp_b.pop_front() : exp_a.pop_front();
		if (got !== e)
			fail($sformatf("write %h, expected %h", got, e));
	endtask

	always @(negedge sys_clk_in) begin
		if (srst_in === 1'b0) begin
			if (ld_req_out === 1'b1)
				req_seen++;
			if (irq_hold_out === 1'b1)
				hold_seen++;
			// every accepted word must sit at the address the rules give
			if (ld_req_out === 1'b1 && ld_ack_in === 1'b1) begin
				va_e = (exp_va.size() > 0) ? exp_va.pop_front() : ~ld_vaddr_out;
				check_val(ld_vaddr_out, va_e);
				check_val(ld_paddr_out, va_e ^ {61'h0, rev_v, 2'b00});
			end
			if (wr_en_a_out === 1'b1)
				check_wr({wr_addr_a_out, wr_data_a_out}, 1'b0);
			if (wr_en_b_out === 1'b1)
				check_wr({wr_addr_b_out, wr_data_b_out}, 1'b1);
		end
	end

	// kind: 0 done, 1 address error, 2 unknown; hold below zero means some
	task automatic run(input logic [15:0] ins, input int kind, input int hold);
		int k;
		int n;
		req_seen = 0;
		hold_seen = 0;
		k = -1;
		n = 0;
		@(posedge sys_clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= ins;
		big_endian_in <= be_v;
		reverse_endian_in <= rev_v;
		do
			@(posedge sys_clk_in);
		while (instr_ready_out !== 1'b1);
		// a further copy stays offered while busy and must be ignored
		instr_in <= {sld_pkg::COPY_MAJOR, 10'h122};
		@(posedge sys_clk_in);
		instr_valid_in <= 1'b0;
		while (k < 0 && n < 400) begin
			@(negedge sys_clk_in);
			n++;
			if (done_out === 1'b1)
				k = 0;
			else if (addr_err_out === 1'b1)
				k = 1;
			else if (unknown_out === 1'b1)
				k = 2;
		end
		@(posedge sys_clk_in);
		check_num(k, kind);
		if (kind == 1) begin
			check_val(bad_vaddr_out, exp_bad);
			check_num(req_seen, 0);
		end
		if (hold < 0)
			check_num(int'(hold_seen > 0), 1);
		else
			check_num(hold_seen, hold);
		check_num(exp_a.size() + exp_b.size() + exp_va.size(), 0);
	endtask

	task automatic exp_load(input logic [4:0] t, input logic [63:0] va);
		logic [63:0] pa;
		logic [63:0] d;
		logic [31:0] w;
		pa = va ^ {61'h0, rev_v, 2'b00};
		d = i_sld_core_model.mem[pa[10:3]];
		w = (va[2] ^ be_v) ? d[63:32] : d[31:0];
		exp_a.push_back({t, {32{w[31]}}, w});
		exp_va.push_back(va);
		exp_gpr[t] = {{32{w[31]}}, w};
	endtask

	task automatic do_load(input logic [15:0] ins, input logic [4:0] t,
			input logic [63:0] va);
		if (va[1:0] != 2'b00) begin
			exp_bad = va;
			run(ins, 1, 0);
		end else begin
			exp_load(t, va);
			run(ins, 0, 0);
		end
	endtask

	task automatic lmult(input logic [1:0] rl, input logic [3:0] off,
			input logic [63:0] sp);
		logic [15:0] ins;
		logic [63:0] va;
		ins = {sld_pkg::POOL16C_MAJOR, rl, off, sld_pkg::LMULT_MINOR};
		va = sp + {58'h0, off, 2'b00};
		if (va[1:0] != 2'b00) begin
			exp_bad = va;
			run(ins, 1, 0);
		end else begin
			for (int i = 0; i <= int'(rl); i++) begin
				exp_load(5'(16 + i), va);
				va = va + 64'h4;
			end
			exp_load(5'h1f, va);
			run(ins, 0, -1);
		end
	endtask

	task automatic set_reg(input int r, input logic [63:0] v);
		exp_gpr[r] = v;
		i_sld_core_model.gpr[r] = v;
	endtask

	initial begin
		logic [63:0] base;
		logic [4:0]  ra;
		logic [4:0]  rb;
		logic [6:0]  off;
		sys_clk_in = 1'b0;
		srst_in = 1'b1;
		instr_valid_in = 1'b0;
		instr_in = 16'h0000;
		big_endian_in = 1'b0;
		reverse_endian_in = 1'b0;
		be_v = 1'b0;
		rev_v = 1'b0;
		void'($urandom(32'hd613));
		for (int r = 0; r < 32; r++)
			set_reg(r, (r == 0) ? 64'h0 : {$urandom, $urandom});
		for (int m = 0; m < 256; m++)
			i_sld_core_model.mem[m] = {$urandom, $urandom};
		repeat (12) @(posedge sys_clk_in);
		check_val(64'({instr_ready_out, done_out, ld_req_out, addr_err_out,
			wr_en_a_out, irq_hold_out}), 64'h20);
		srst_in <= 1'b0;
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			ra = 5'(1 + $urandom % 31);
			rb = (i == 0) ? 5'h00 : 5'($urandom);
			exp_a.push_back({ra, exp_gpr[rb]});
			exp_gpr[ra] = exp_gpr[rb];
			run({sld_pkg::COPY_MAJOR, ra, rb}, 0, 0);
		end
		$display("test single copy done");
		for (int i = 0; i < 8; i++) begin
			exp_a.push_back({5'(dst1_t[i]), exp_gpr[src_t[i]]});
			exp_b.push_back({5'(dst2_t[i]), exp_gpr[src_t[7 - i]]});
			exp_gpr[dst1_t[i]] = exp_gpr[src_t[i]];
			exp_gpr[dst2_t[i]] = exp_gpr[src_t[7 - i]];
			run({PAIR_MAJ, 3'(i), 3'(i), 3'(7 - i), 1'(i)}, 0, 1);
		end
		$display("test pair copy done");
		for (int e = 0; e < 4; e++) begin
			be_v = e[0];
			rev_v = e[1];
			for (int i = 0; i < 8; i++) begin
				off = (i == 0) ? 7'h40 : (i == 1) ? 7'h3f : 7'($urandom);
				base = 64'h400 + ((i > 5) ? 64'(i - 5) : 64'h0);
				i_sld_core_model.ack_delay = i % 4;
				set_reg(28, base);
				// codes 0..5 name registers 2..7, codes 6 and 7 name 16 and 17
				ra = (i < 6) ? 5'(i + 2) : 5'(i + 10);
				do_load({sld_pkg::GP_LOAD_MAJOR, 3'(i), off}, ra,
					base + {{55{off[6]}}, off, 2'b00});
			end
		end
		$display("test global pointer load done");
		for (int i = 0; i < 12; i++) begin
			be_v = i[0];
			rev_v = i[1];
			ra = 5'(1 + $urandom % 31);
			rb = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
			base = 64'h200 + ((i > 9) ? 64'(i - 9) : 64'h0);
			i_sld_core_model.ack_delay = i % 3;
			set_reg(29, base);
			do_load({SP_MAJ, ra, rb}, ra, base + {57'h0, rb, 2'b00});
		end
		$display("test stack pointer load done");
		for (int i = 0; i < 10; i++) begin
			be_v = i[1];
			rev_v = i[0];
			off = (i < 4) ? 7'h0f : 7'($urandom);
			base = 64'h600 + ((i > 7) ? 64'(i - 7) : 64'h0);
			i_sld_core_model.ack_delay = i % 3;
			set_reg(29, base);
			lmult(2'(i), off[3:0], base);
		end
		$display("test load multiple done");
		run(16'hfc00, 2, 0);
		run({sld_pkg::POOL16C_MAJOR, 10'h000}, 2, 0);
		$display("test unknown done");
		report_and_stop();
	end

	initial begin
		repeat (40000) @(posedge sys_clk_in);
		fail("watchdog expired");
		report_and_stop();
	end
endmodule
`default_nettype wire
